// File: design/lscb_pkg.sv
/*
  Constants, types and register layout of the low-speed clock select and
  backup block. Assumes a 20 MHz reference clock for all timing counts.
*/
package lscb_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam int CNT_W = 17;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h1;

  // Mode register fields
  localparam int MODE_OSC_LSB = 0;
  localparam int MODE_SEL0_BIT = 2;
  localparam int MODE_SEL1_BIT = 3;
  localparam int MODE_OUTSEL_BIT = 4;

  // Status register fields
  localparam int STAT_UNSTABLE_BIT = 0;
  localparam int STAT_STOPDET_BIT = 1;
  localparam int STAT_L0RC_BIT = 8;
  localparam int STAT_L0XT_BIT = 9;
  localparam int STAT_L1RC_BIT = 10;
  localparam int STAT_L1XT_BIT = 11;

  // Oscillator mode codes
  localparam logic [1:0] OSC_OFF = 2'h0;
  localparam logic [1:0] OSC_XTAL = 2'h1;
  localparam logic [1:0] OSC_EXT = 2'h2;

  // Timing
  localparam int CLK_KHZ = 20000;
  localparam int CLK_MHZ = 20;
  localparam int START_EDGES = 512;
  localparam int T_RC_START_US = 100;
  localparam int T_STAB_US = 100;
  localparam int WAKE_CYC = (T_RC_START_US + T_STAB_US) * CLK_MHZ;
  localparam int T_DET_NORM_MS = 4;
  localparam int T_DET_DEEP_MS = 5;
  localparam int DET_NORM_CYC_DEF = T_DET_NORM_MS * CLK_KHZ;
  localparam int DET_DEEP_CYC_DEF = T_DET_DEEP_MS * CLK_KHZ;

  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_RUN = 4'h2,
    ST_STOP = 4'h4,
    ST_WAKE = 4'h8
  } lscb_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lscb_req_t;

  typedef struct packed {
    lscb_state_t st;
    logic rc_s1;
    logic rc_s2;
    logic rc_d;
    logic xt_s1;
    logic xt_s2;
    logic xt_d;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] quiet;
    logic [1:0] osc_mode;
    logic [1:0] src_sel;
    logic out_sel;
    logic unstable;
    logic stop_flag;
    logic [1:0] act_sel;
    logic [1:0] act_en;
    logic [1:0] clk_out;
    logic out_act;
    logic low_out;
    logic irq;
    logic run;
    logic xt_en;
    logic ign_a;
    logic ign_b;
    logic [DATA_W-1:0] rdata;
  } lscb_regs_t;

endpackage

// File: design/lscb_top.sv
/*
  Low-speed clock select and backup: builds two low-speed clocks from the
  internal RC or the crystal/external source, holds the CPU at start and
  wake, watches the crystal for a stop and falls back to RC.
  Assumes both source clocks are far slower than REF_CLK_I and arrive
  asynchronously; timer X, standby control and other resets are on
  REF_CLK_I.
*/
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - each clock picks RC or crystal by select
// - output pin carries clock 0 or 1
// - CPU held until 512 source edges counted
// - power-on or pin reset selects RC
// - wake from stop waits RC start plus stabilization
// - crystal mode and external clock mode
// - mode makes one port setting ignored
// - stopped crystal falls back to RC
// - channel 1 fallback may be disabled
// - stop mode halts crystal; wake on RC
// - crystal starts on mode write while running
// - mode kept across other system resets
// - backup entered and interrupt raised after stop
// - detection time 4 ms, 5 ms deep halt
// - interrupt once until flag cleared
// - clock 0 follows stopped crystal, then RC
// - channel 1 without fallback stays on crystal
// - clock states follow the status table
// - external mode behaves as crystal mode
// - writing one clears stop detect flag
module lscb_top
  import lscb_pkg::*;
#(
  parameter int DET_NORM_CYC = DET_NORM_CYC_DEF,
  parameter int DET_DEEP_CYC = DET_DEEP_CYC_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic SYS_RST_I,
  input wire logic RC_CLK_I,
  input wire logic XT_CLK_I,
  input wire logic STOP_I,
  input wire logic DEEP_HALT_I,
  input wire logic TMRX_DONE_I,
  input wire logic CH1_BACKUP_EN_I,
  input wire logic CH1_CLK_EN_I,
  input wire lscb_req_t REQ_I,
  output logic [DATA_W-1:0] RDATA_O,
  output logic LOW_SPEED_CLOCK_0_O,
  output logic LOW_SPEED_CLOCK_1_O,
  output logic LOW_CLOCK_OUT_O,
  output logic CPU_RUN_O,
  output logic XT_OSC_EN_O,
  output logic BACKUP_IRQ_O,
  output logic XT_PORT_A_IGNORE_O,
  output logic XT_PORT_B_IGNORE_O
);

  logic rst_meta;
  logic rst_sync;
  lscb_regs_t r;
  lscb_regs_t n;

  function automatic logic src_lvl(input logic sel, input logic rc, input logic xt);
    return sel ? xt : rc;
  endfunction

  function automatic logic osc_on(input logic [1:0] mode);
    return (mode == OSC_XTAL) || (mode == OSC_EXT);
  endfunction

  // Reset release through two flops
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  always_comb begin
    logic rc_rise;
    logic xt_rise;
    logic armed;
    logic detect;
    logic cur;
    logic nsrc;
    logic forced;
    logic [1:0] want_en;
    logic [CNT_W-1:0] det_lim;
    logic [1:0] wmode;
    rc_rise = 1'b0;
    xt_rise = 1'b0;
    armed = 1'b0;
    detect = 1'b0;
    cur = 1'b0;
    nsrc = 1'b0;
    forced = 1'b0;
    want_en = 2'h0;
    det_lim = '0;
    wmode = 2'h0;
    n = r;
    n.rc_s1 = RC_CLK_I;
    n.rc_s2 = r.rc_s1;
    n.rc_d = r.rc_s2;
    n.xt_s1 = XT_CLK_I;
    n.xt_s2 = r.xt_s1;
    n.xt_d = r.xt_s2;
    n.irq = 1'b0;
    rc_rise = r.rc_s2 & ~r.rc_d;
    xt_rise = r.xt_s2 & ~r.xt_d;

    unique case (r.st)
      ST_START: begin
        if (src_lvl(r.src_sel[0], rc_rise, xt_rise)) begin
          n.cnt = r.cnt + CNT_W'(1);
          if (r.cnt == CNT_W'(START_EDGES - 1)) begin
            n.st = ST_RUN;
            n.cnt = '0;
          end
        end
      end
      ST_RUN: begin
        if (STOP_I) begin
          n.st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!STOP_I) begin
          n.st = ST_WAKE;
          n.cnt = '0;
        end
      end
      ST_WAKE: begin
        n.cnt = r.cnt + CNT_W'(1);
        if (r.cnt == CNT_W'(WAKE_CYC - 1)) begin
          n.st = ST_RUN;
          n.cnt = '0;
        end
      end
    endcase
    // Mode register survives; only the start sequence restarts
    if (SYS_RST_I) begin
      n.st = ST_START;
      n.cnt = '0;
    end

    // Stabilization wait ends on timer X
    if (TMRX_DONE_I && osc_on(r.osc_mode)) begin
      n.unstable = 1'b0;
    end

    if (REQ_I.wr && r.st == ST_RUN && !SYS_RST_I) begin
      if (REQ_I.addr == ADDR_MODE) begin
        wmode = REQ_I.wdata[MODE_OSC_LSB +: 2];
        n.osc_mode = wmode;
        n.out_sel = REQ_I.wdata[MODE_OUTSEL_BIT];
        if (!osc_on(wmode)) begin
          n.src_sel = 2'h0;
          n.unstable = 1'b1;
        end else begin
          if (!osc_on(r.osc_mode)) begin
            n.unstable = 1'b1;
          end
          // Crystal may be taken only once stable, and not in backup unless on channel 1 with its fallback disabled
          if (!REQ_I.wdata[MODE_SEL0_BIT]) begin
            n.src_sel[0] = 1'b0;
          end else if (!n.unstable && !r.stop_flag) begin
            n.src_sel[0] = 1'b1;
          end
          if (!REQ_I.wdata[MODE_SEL1_BIT]) begin
            n.src_sel[1] = 1'b0;
          end else if (!n.unstable && (!r.stop_flag || !CH1_BACKUP_EN_I)) begin
            n.src_sel[1] = 1'b1;
          end
        end
      end else if (REQ_I.addr == ADDR_STAT) begin
        if (REQ_I.wdata[STAT_STOPDET_BIT]) begin
          n.stop_flag = 1'b0;
        end
      end
    end

    // Silence watchdog on the crystal
    armed = osc_on(r.osc_mode) && !r.unstable && r.st != ST_STOP;
    det_lim = DEEP_HALT_I ? CNT_W'(DET_DEEP_CYC) : CNT_W'(DET_NORM_CYC);
    if (!armed || (r.xt_s2 != r.xt_d)) begin
      n.quiet = '0;
    end else if (r.quiet < det_lim) begin
      n.quiet = r.quiet + CNT_W'(1);
    end
    detect = armed && (r.quiet >= det_lim);
    if (detect) begin
      n.unstable = 1'b1;
      n.src_sel[0] = 1'b0;
      if (CH1_BACKUP_EN_I) begin
        n.src_sel[1] = 1'b0;
      end
      // Detection wins over a clear in the same cycle
      n.stop_flag = 1'b1;
      if (!r.stop_flag) begin
        n.irq = 1'b1;
      end
    end

    if (n.st == ST_STOP) begin
      n.src_sel = 2'h0;
      n.unstable = 1'b1;
    end
    n.xt_en = osc_on(n.osc_mode) && n.st != ST_STOP;
    n.ign_a = n.osc_mode == OSC_XTAL;
    n.ign_b = n.osc_mode == OSC_EXT;
    n.run = n.st == ST_RUN;

    // Clock gates; channel 1 is off without fallback and without crystal
    want_en[0] = n.st == ST_RUN;
    want_en[1] = want_en[0] && CH1_CLK_EN_I && (CH1_BACKUP_EN_I || n.src_sel[1]);
    for (int ch = 0; ch < 2; ch++) begin
      cur = src_lvl(r.act_sel[ch], r.rc_s2, r.xt_s2);
      nsrc = src_lvl(n.src_sel[ch], r.rc_s2, r.xt_s2);
      // A stalled crystal may hold high; leaving it then cannot make a runt
      forced = !n.src_sel[ch] && n.unstable;
      if (r.act_sel[ch] != n.src_sel[ch] && !nsrc && ((!cur && !r.clk_out[ch]) || forced)) begin
        n.act_sel[ch] = n.src_sel[ch];
      end
      cur = src_lvl(n.act_sel[ch], r.rc_s2, r.xt_s2);
      if (r.act_en[ch] != want_en[ch] && !cur && !r.clk_out[ch]) begin
        n.act_en[ch] = want_en[ch];
      end
      n.clk_out[ch] = n.act_en[ch] & cur;
    end
    if (r.out_act != n.out_sel && !n.clk_out[0] && !n.clk_out[1]) begin
      n.out_act = n.out_sel;
    end
    n.low_out = n.clk_out[n.out_act];

    n.rdata = '0;
    if (REQ_I.rd) begin
      if (REQ_I.addr == ADDR_MODE) begin
        n.rdata[MODE_OSC_LSB +: 2] = r.osc_mode;
        n.rdata[MODE_SEL0_BIT] = r.src_sel[0];
        n.rdata[MODE_SEL1_BIT] = r.src_sel[1];
        n.rdata[MODE_OUTSEL_BIT] = r.out_sel;
      end else if (REQ_I.addr == ADDR_STAT) begin
        n.rdata[STAT_UNSTABLE_BIT] = r.unstable;
        n.rdata[STAT_STOPDET_BIT] = r.stop_flag;
        n.rdata[STAT_L0RC_BIT] = !r.act_sel[0];
        n.rdata[STAT_L0XT_BIT] = r.act_sel[0];
        n.rdata[STAT_L1RC_BIT] = want_en[1] && !r.act_sel[1];
        n.rdata[STAT_L1XT_BIT] = want_en[1] && r.act_sel[1];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
      r <= '0;
      r.st <= ST_START;
      r.unstable <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign RDATA_O = r.rdata;
  assign LOW_SPEED_CLOCK_0_O = r.clk_out[0];
  assign LOW_SPEED_CLOCK_1_O = r.clk_out[1];
  assign LOW_CLOCK_OUT_O = r.low_out;
  assign CPU_RUN_O = r.run;
  assign XT_OSC_EN_O = r.xt_en;
  assign BACKUP_IRQ_O = r.irq;
  assign XT_PORT_A_IGNORE_O = r.ign_a;
  assign XT_PORT_B_IGNORE_O = r.ign_b;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!rst_sync);

  hold_cpu_a: assert property (r.st == ST_START |=> !CPU_RUN_O || $past(r.cnt) == CNT_W'(START_EDGES - 1))
    else $error("CPU released before start count");
  por_rc_a: assert property ($rose(rst_sync) |-> !r.src_sel[0] && !LOW_SPEED_CLOCK_0_O)
    else $error("Clock 0 not on RC after reset");
  wake_hold_a: assert property ($fell(STOP_I) && r.st == ST_STOP |=> !CPU_RUN_O [*8])
    else $error("CPU ran too early after wake");
  stop_osc_a: assert property (r.st == ST_STOP |-> !XT_OSC_EN_O && r.src_sel == 2'h0)
    else $error("Crystal running in stop mode");
  port_ign_a: assert property (XT_PORT_A_IGNORE_O |-> !XT_PORT_B_IGNORE_O && r.osc_mode == OSC_XTAL)
    else $error("Port ignore does not match mode");
  irq_edge_a: assert property ($rose(r.stop_flag) |-> BACKUP_IRQ_O && !r.src_sel[0] && r.unstable)
    else $error("Detection without interrupt or fallback");
  irq_once_a: assert property (BACKUP_IRQ_O |-> !$past(r.stop_flag))
    else $error("Repeat interrupt before flag clear");
  ch1_keep_a: assert property ($rose(r.stop_flag) && !CH1_BACKUP_EN_I && $past(r.src_sel[1])
      |-> r.src_sel[1])
    else $error("Channel 1 left crystal without fallback");
  flag_clr_a: assert property (REQ_I.wr && REQ_I.addr == ADDR_STAT && REQ_I.wdata[STAT_STOPDET_BIT]
      && r.st == ST_RUN && !SYS_RST_I && r.stop_flag && r.quiet == '0 |=> !r.stop_flag)
    else $error("Stop flag not cleared by write");
  ch1_off_a: assert property (!r.act_en[1] && !$past(r.act_en[1]) |-> !LOW_SPEED_CLOCK_1_O)
    else $error("Channel 1 clock running while off");
  xt_start_a: assert property (REQ_I.wr && REQ_I.addr == ADDR_MODE && r.st == ST_RUN && !SYS_RST_I
      && REQ_I.wdata[MODE_OSC_LSB +: 2] == OSC_XTAL && !STOP_I |=> XT_OSC_EN_O)
    else $error("Crystal not started by mode write");

  start_done_c: cover property (r.st == ST_START ##1 r.st == ST_RUN);
  xtal_sel_c: cover property (r.act_sel[0] && LOW_SPEED_CLOCK_0_O);
  backup_c: cover property (BACKUP_IRQ_O);
  wake_c: cover property (r.st == ST_WAKE ##1 r.st == ST_RUN);

endmodule

`default_nettype wire

// File: sim/lscb_osc_model.sv
/*
  Behavioural model of the two 32k sources: the internal RC and the
  crystal or external clock. Assumes the crystal enable comes from the
  block and that the bench can make the crystal fail on purpose.
*/
`timescale 1ns/100ps
`default_nettype none
module lscb_osc_model #(
  parameter int RC_HALF_NS = 200,
  parameter int XT_HALF_NS = 250
) (
  output logic rc_clk_o,
  output logic xt_clk_o,
  input wire logic xt_en_i,
  input wire logic xt_alive_i
);
  initial begin
    rc_clk_o = 1'b0;
    xt_clk_o = 1'b0;
  end
  // RC runs scaled up so the start counts stay short
  always #RC_HALF_NS rc_clk_o = ~rc_clk_o;
  // Crystal swings only while enabled and healthy; a stopped crystal rests low
  always #XT_HALF_NS xt_clk_o = (xt_en_i & xt_alive_i) ? ~xt_clk_o : 1'b0;
endmodule
`default_nettype wire

// File: sim/test_lscb_top.sv
/*
  Self-checking bench of the low-speed clock select and backup block.
  Assumes the oscillator model beside it and a 20 MHz reference clock.
*/
`timescale 1ns/100ps
`default_nettype none
module test_lscb_top
  import lscb_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_rst = 1'b0;
  logic stop = 1'b0;
  logic tmrx = 1'b0;
  logic bu_en = 1'b1;
  logic alive = 1'b1;
  logic deep = 1'b0;
  logic ls0, ls1, lout;
  lscb_req_t req = '0;
  logic [15:0] rdata;
  logic run, xt_en, irq, ign_a, ign_b, rc, xt;
  int fails = 0;
  int tests_run = 0;
  int n;

  always #25 clk = ~clk;

  lscb_osc_model osc (.rc_clk_o(rc), .xt_clk_o(xt), .xt_en_i(xt_en), .xt_alive_i(alive));

  lscb_top #(.DET_NORM_CYC(200), .DET_DEEP_CYC(250)) uut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .SYS_RST_I(sys_rst), .RC_CLK_I(rc),
    .XT_CLK_I(xt), .STOP_I(stop), .DEEP_HALT_I(deep), .TMRX_DONE_I(tmrx),
    .CH1_BACKUP_EN_I(bu_en), .CH1_CLK_EN_I(1'b1), .REQ_I(req), .RDATA_O(rdata),
    .LOW_SPEED_CLOCK_0_O(ls0), .LOW_SPEED_CLOCK_1_O(ls1), .LOW_CLOCK_OUT_O(lout),
    .CPU_RUN_O(run), .XT_OSC_EN_O(xt_en),
    .BACKUP_IRQ_O(irq), .XT_PORT_A_IGNORE_O(ign_a), .XT_PORT_B_IGNORE_O(ign_b)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask

  // Counts cycles until the CPU runs (which 0) or the backup pulse (which 1)
  task automatic wait_for(input int which, input int lim, output int k);
    logic s;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
      s = which ? irq : run;
    end while (s !== 1'b1 && k < lim);
    if (s !== 1'b1) begin
      fails++;
      $display("unexpected wait %0d expected 1 seen %b", which, s);
      test_done();
    end
  endtask

  // Counts rising edges of clock 0 (which 0), clock 1 (1) or the output pin (2)
  task automatic count_rise(input int which, input int cyc, output int k);
    logic p;
    logic s;
    k = 0;
    p = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      #1 s = (which == 0) ? ls0 : ((which == 1) ? ls1 : lout);
      if (s === 1'b1 && p !== 1'b1) begin
        k++;
      end
      p = s;
    end
  endtask

  task automatic stab_done();
    repeat (20) @(posedge clk);
    tmrx <= 1'b1;
    @(posedge clk);
    tmrx <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_for(0, 5000, n);
    chk("start_count", 16'(n >= 4000 && n <= 4300), 16'h0001);
    rchk("stat_reset", ADDR_STAT, 16'h0501);
    wr(ADDR_MODE, 16'h0004);
    rchk("sel_refused", ADDR_MODE, 16'h0000);
    wr(ADDR_MODE, 16'h0001);
    #1 chk("xt_enable", {15'h0000, xt_en}, 16'h0001);
    chk("ignore_xt", {14'h0000, ign_a, ign_b}, 16'h0002);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_MODE, 16'h0002);
    #1 chk("ignore_ext", {14'h0000, ign_a, ign_b}, 16'h0001);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_MODE, 16'h0001);
    stab_done();
    wr(ADDR_MODE, 16'h001D);
    repeat (40) @(posedge clk);
    rchk("mode_xt", ADDR_MODE, 16'h001D);
    rchk("stat_xt", ADDR_STAT, 16'h0A00);
    count_rise(2, 100, n);
    chk("out_pin_xt", 16'(n >= 9 && n <= 11), 16'h0001);
    count_rise(0, 100, n);
    chk("clk0_xt", 16'(n >= 9 && n <= 11), 16'h0001);
    alive <= 1'b0;
    wait_for(1, 400, n);
    chk("detect_time", 16'(n >= 180 && n <= 260), 16'h0001);
    repeat (20) @(posedge clk);
    rchk("stat_backup", ADDR_STAT, 16'h0503);
    rchk("mode_backup", ADDR_MODE, 16'h0011);
    count_rise(0, 96, n);
    chk("clk0_backup", 16'(n >= 11 && n <= 13), 16'h0001);
    wr(ADDR_STAT, 16'h0002);
    rchk("flag_clear", ADDR_STAT, 16'h0501);
    // Channel 1 on the crystal with its fallback disabled
    bu_en <= 1'b0;
    alive <= 1'b1;
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_MODE, 16'h0001);
    stab_done();
    wr(ADDR_MODE, 16'h0009);
    repeat (40) @(posedge clk);
    rchk("stat_ch1", ADDR_STAT, 16'h0900);
    deep <= 1'b1;
    alive <= 1'b0;
    wait_for(1, 400, n);
    chk("detect_deep", 16'(n >= 230 && n <= 320), 16'h0001);
    deep <= 1'b0;
    repeat (20) @(posedge clk);
    rchk("stat_no_fallback", ADDR_STAT, 16'h0903);
    rchk("mode_no_fallback", ADDR_MODE, 16'h0009);
    count_rise(1, 100, n);
    chk("clk1_stalled", 16'(n), 16'h0000);
    count_rise(0, 96, n);
    chk("clk0_rc", 16'(n >= 11 && n <= 13), 16'h0001);
    // Stop mode and wake-up
    bu_en <= 1'b1;
    alive <= 1'b1;
    stop <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("stop_state", {14'h0000, xt_en, run}, 16'h0000);
    chk("stop_clocks", {14'h0000, ls0, ls1}, 16'h0000);
    stop <= 1'b0;
    wait_for(0, 5000, n);
    chk("wake_time", 16'(n >= 3990 && n <= 4100), 16'h0001);
    rchk("stat_wake", ADDR_STAT, 16'h0503);
    // Other system reset keeps the mode and the crystal
    wr(ADDR_MODE, 16'h0001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_for(0, 5000, n);
    chk("restart_count", 16'(n >= 4000 && n <= 4300), 16'h0001);
    rchk("mode_kept", ADDR_MODE, 16'h0001);
    chk("xt_kept", {15'h0000, xt_en}, 16'h0001);
    test_done();
  end
endmodule
`default_nettype wire
